// file: hdl/fpg_flash_guard.sv
// Flash controller lock, unlock, sector protect and program/erase sequencer
//
// Behaviour
// R1 - Write-protect option 0 refuses user program and erase; debugger mass erase allowed.
// R2 - Write-protect option 1 permits program and erase, subject to other protections.
// R3 - Every reset locks the controller.
// R4 - Software unlocks: page select, 73h, 8Ch, page select again.
// R5 - Second page select compared to first; mismatch locks, match activates page.
// R6 - Program and erase blocked by cleared option or protected sector.
// R7 - Any control write other than erase commands ends programming and locks.
// R8 - Eight sectors, each one eighth of memory but never below one page.
// R9 - Writing 5Eh maps shared address to sector protect; other values undo it.
// R10 - User writes to sector protect only set bits.
// R11 - Sector protect resets to zero; set bits block until system reset.
// R12 - Control write 00h returns to reset state.
// R13 - Programming clears bits only; erase sets bytes to FFh.
// R14 - Page stays unlocked after each programmed byte.
// R15 - Processor stalled during program or erase, resumed at end.
// R16 - Software programs each byte at most twice between erases.
// R17 - 95h while unlocked erases active page if unprotected, then locks.
// R18 - Debugger polls status until page erase finishes.
// R19 - 63h unlocked with debugger erases all memory, then locks.
// R20 - Debugger ignores protections, any page, clears protect bits, skips second select.
// R21 - Debugger may rewrite page select while unlocked; mass erase accepted.
// R22 - Only one page open at a time; new page needs full unlock.
// R23 - Invalid value or out-of-order write during unlock locks.
// R24 - Six-bit status field encodes controller state.
// R25 - Page field gives address bits 15 to 9.
// R26 - Software loads clock frequency in kHz before program or erase; the guard has no such register and times programming with the fixed FPG_CLK_MHZ.
// R27 - Rejected operation leaves memory alone and controller locked.
`timescale 1ns/10ps
module fpg_flash_guard
   import fpg_pkg::*;
#(
   parameter int ADDR_W     = 16,
   parameter int FLASH_SIZE = 24576,
   parameter int PAGE_SIZE  = 512
)(
   input  wire logic              ref_clk_i,      // System clock
   input  wire logic              reset_i,        // Synchronous reset, active high
   input  wire logic              wp_option_i,    // write_protect_option bit
   input  wire logic              debugger_port_i,// Access comes from debugger
   input  wire logic              reg_wr_i,       // Register write strobe
   input  wire logic              reg_rd_i,       // Register read strobe
   input  wire logic [11:0]       reg_addr_i,     // Register address
   input  wire logic [7:0]        reg_wdata_i,    // Register write data
   input  wire logic              prog_req_i,     // Byte program request
   input  wire logic [ADDR_W-1:0] prog_addr_i,    // Byte program address
   input  wire logic [7:0]        prog_data_i,    // Byte program data
   input  wire logic [7:0]        mem_rdata_i,    // Current flash byte at mem_addr_o
   output logic [7:0]             reg_rdata_o,    // Register read data
   output logic                   cpu_stall_o,    // Stall processor fetch
   output logic                   mem_we_o,       // Flash byte write strobe
   output logic [ADDR_W-1:0]      mem_addr_o,     // Flash byte address
   output logic [7:0]             mem_wdata_o,    // Flash byte data
   output logic [7:0]             sector_prot_o   // Sector protect bits
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(FLASH_SIZE - 1);
   localparam logic [ADDR_W-1:0] PAGE_LAST = ADDR_W'(PAGE_SIZE - 1);

   typedef struct packed {
      fpg_state_type     state;
      fpg_op_type        op;
      logic [7:0]        page;
      logic [7:0]        page_first;
      logic [7:0]        prot;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] end_addr;
      logic [7:0]        data;
      logic [7:0]        cnt;
      logic              stay_open;
      logic [7:0]        rdata;
      logic              stall;
      logic              we;
   } fpg_regs_type;

   fpg_regs_type r_reg;
   fpg_regs_type r_next;

   logic       ctrl_wr;
   logic       page_wr;
   logic       allowed;
   logic       sect_prot;
   logic [5:0] status;

   fpg_sector_map #(
      .ADDR_W     (ADDR_W),
      .FLASH_SIZE (FLASH_SIZE),
      .PAGE_SIZE  (PAGE_SIZE)
   ) u_map (
      .addr_i      (r_reg.addr),
      .prot_i      (r_reg.prot),
      .sector_o    (),
      .protected_o (sect_prot)
   );

   function automatic logic [ADDR_W-1:0] page_base(input logic [7:0] pg);
      page_base = ADDR_W'({pg[FPG_PAGE_BITS-1:0], 9'h000}); // R25
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      r_next   = r_reg;
      r_next.we = 1'b0;
      ctrl_wr  = reg_wr_i && (reg_addr_i == FPG_CTRL_ADDR);
      page_wr  = reg_wr_i && (reg_addr_i == FPG_PAGE_ADDR);
      allowed  = 1'b0;
      case (r_reg.state)
         FPG_BUSY: ;
         default:
         begin
            if (ctrl_wr)
            begin
               r_next.state = FPG_LOCKED; // R7 R12 R23
               case (reg_wdata_i)
                  FPG_CMD_UNLOCK1:
                     if (r_reg.state == FPG_LOCKED)
                        r_next.state = FPG_GOT_FIRST; // R4
                  FPG_CMD_UNLOCK2:
                     if (r_reg.state == FPG_GOT_FIRST)
                        r_next.state = debugger_port_i ? FPG_UNLOCKED : FPG_GOT_SECOND; // R20
                  FPG_CMD_PROT_SEL:
                     r_next.state = FPG_PROT_SEL; // R9
                  FPG_CMD_PAGE_ERASE:
                     if (r_reg.state == FPG_UNLOCKED)
                     begin
                        r_next.state    = FPG_BUSY; // R17
                        r_next.op       = FPG_OP_PAGE_ERASE;
                        r_next.addr     = page_base(r_reg.page);
                        r_next.end_addr = page_base(r_reg.page) + PAGE_LAST;
                     end
                  FPG_CMD_MASS_ERASE:
                     if (r_reg.state == FPG_UNLOCKED && debugger_port_i)
                     begin
                        r_next.state    = FPG_BUSY; // R19 R21
                        r_next.op       = FPG_OP_MASS_ERASE;
                        r_next.addr     = '0;
                        r_next.end_addr = LAST_ADDR;
                     end
                  default: ;
               endcase
            end
            else if (page_wr)
            begin
               if (r_reg.state == FPG_PROT_SEL)
                  r_next.prot = debugger_port_i ? reg_wdata_i
                                                : (r_reg.prot | reg_wdata_i); // R10 R20
               else if (r_reg.state == FPG_GOT_SECOND)
               begin
                  if (reg_wdata_i == r_reg.page_first) // R5
                  begin
                     r_next.state = FPG_UNLOCKED;
                     r_next.page  = reg_wdata_i;
                  end
                  else
                     r_next.state = FPG_LOCKED; // R22
               end
               else if (r_reg.state == FPG_LOCKED || debugger_port_i) // R21
               begin
                  r_next.page       = reg_wdata_i;
                  r_next.page_first = reg_wdata_i;
               end
               else
                  r_next.state = FPG_LOCKED; // R23
            end
            else if (prog_req_i && r_reg.state == FPG_UNLOCKED)
            begin
               if (debugger_port_i ||
                   prog_addr_i[ADDR_W-1:FPG_PAGE_LSB] ==
                   (ADDR_W-FPG_PAGE_LSB)'(r_reg.page[FPG_PAGE_BITS-1:0])) // R20 R22
               begin
                  r_next.state     = FPG_BUSY; // R15
                  r_next.op        = FPG_OP_PROGRAM;
                  r_next.addr      = prog_addr_i;
                  r_next.end_addr  = prog_addr_i;
                  r_next.data      = prog_data_i;
                  r_next.stay_open = 1'b1; // R14
               end
            end
            if (r_next.state == FPG_BUSY)
            begin
               r_next.cnt = (r_next.op == FPG_OP_PROGRAM) ? 8'(FPG_PROG_CYCLES)
                                                           : 8'(FPG_ERASE_CYCLES);
               r_next.stay_open = (r_next.op == FPG_OP_PROGRAM);
            end
         end
      endcase

      if (r_reg.state == FPG_BUSY)
      begin
         // User access obeys option bit and sector bits; debugger bypasses both
         allowed = debugger_port_i || (wp_option_i && !sect_prot); // R1 R2 R6 R20
         // Step on only once the byte strobe has gone out at the old address
         if (r_reg.we)
            r_next.addr = r_reg.addr + ADDR_W'(1);
         if (r_reg.cnt != 8'h00)
            r_next.cnt = r_reg.cnt - 8'h01;
         else
         begin
            if (allowed)
            begin
               r_next.we   = 1'b1;
               r_next.data = (r_reg.op == FPG_OP_PROGRAM) ? (mem_rdata_i & r_reg.data)
                                                          : FPG_ERASED_BYTE; // R13
            end
            if (r_reg.addr == r_reg.end_addr || !allowed) // R27
               r_next.state = (r_reg.stay_open && allowed) ? FPG_UNLOCKED : FPG_LOCKED;
            else
               r_next.cnt = 8'(FPG_ERASE_CYCLES);
         end
      end

      r_next.stall = (r_next.state == FPG_BUSY); // R15
      r_next.rdata = (r_reg.state == FPG_PROT_SEL) ? r_reg.prot : r_reg.page;
      if (reg_rd_i && reg_addr_i == FPG_CTRL_ADDR)
         r_next.rdata = {2'b00, status}; // R24
   end

   always_comb
   begin
      case (r_reg.state)
         FPG_LOCKED:     status = FPG_ST_LOCKED; // R24
         FPG_GOT_FIRST:  status = FPG_ST_UNLOCK1;
         FPG_GOT_SECOND: status = FPG_ST_UNLOCK2;
         FPG_UNLOCKED:   status = FPG_ST_UNLOCKED;
         FPG_PROT_SEL:   status = FPG_ST_PROT;
         FPG_BUSY:       status = (r_reg.op == FPG_OP_PROGRAM)    ? FPG_ST_PROGRAM :
                                  (r_reg.op == FPG_OP_PAGE_ERASE) ? FPG_ST_PAGE_ERASE
                                                                  : FPG_ST_MASS_ERASE;
         default:        status = FPG_ST_LOCKED;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         r_reg            <= '0;
         r_reg.state      <= FPG_LOCKED; // R3
         r_reg.op         <= FPG_OP_PROGRAM;
         r_reg.prot       <= FPG_PROT_RESET; // R11
         r_reg.page       <= FPG_PAGE_RESET;
         r_reg.page_first <= FPG_PAGE_RESET;
      end
      else
         r_reg <= r_next;
   end

   assign reg_rdata_o   = r_reg.rdata;
   assign cpu_stall_o   = r_reg.stall;
   assign mem_we_o      = r_reg.we;
   assign mem_addr_o    = r_reg.addr;
   assign mem_wdata_o   = r_reg.data;
   assign sector_prot_o = r_reg.prot;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_reset_locks: assert property (@(posedge ref_clk_i) // R3
      reset_i |=> r_reg.state == FPG_LOCKED && r_reg.prot == 8'h00)
      else $error("not locked after reset");
   a_prot_set_only: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
      !debugger_port_i |=> (r_reg.prot & $past(r_reg.prot)) == $past(r_reg.prot))
      else $error("protect bit cleared by user");
   a_zero_cmd_locks: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
      ctrl_wr && reg_wdata_i == FPG_CMD_RESET && r_reg.state != FPG_BUSY
      |=> r_reg.state == FPG_LOCKED)
      else $error("00h did not lock");
   a_wp_blocks_we: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1
      r_reg.state == FPG_BUSY && !wp_option_i && !debugger_port_i |=> !mem_we_o)
      else $error("write despite write protect");
   a_stall_busy: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R15
      r_reg.state == FPG_BUSY |-> cpu_stall_o)
      else $error("processor not stalled");
   a_prog_clears: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
      mem_we_o && $past(r_reg.op) == FPG_OP_PROGRAM
      |-> (mem_wdata_o & ~$past(mem_rdata_i)) == 8'h00)
      else $error("program set a bit");
   a_mismatch_locks: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R5
      page_wr && r_reg.state == FPG_GOT_SECOND && reg_wdata_i != r_reg.page_first
      |=> r_reg.state == FPG_LOCKED)
      else $error("mismatch did not lock");
   a_sector_blocks: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
      r_reg.state == FPG_BUSY && sect_prot && !debugger_port_i |=> !mem_we_o)
      else $error("write into protected sector");
   a_page_erase_ends: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R17
      r_reg.state == FPG_BUSY && r_reg.op == FPG_OP_PAGE_ERASE && r_next.state != FPG_BUSY
      |=> r_reg.state == FPG_LOCKED)
      else $error("page erase did not relock");
   a_user_no_mass: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R19
      ctrl_wr && reg_wdata_i == FPG_CMD_MASS_ERASE && !debugger_port_i
      && r_reg.state != FPG_BUSY |=> r_reg.state != FPG_BUSY)
      else $error("user started mass erase");

   c_unlocked: cover property (@(posedge ref_clk_i) r_reg.state == FPG_UNLOCKED);
   c_page_erase: cover property (@(posedge ref_clk_i)
      r_reg.state == FPG_BUSY && r_reg.op == FPG_OP_PAGE_ERASE);
   c_program_we: cover property (@(posedge ref_clk_i)
      mem_we_o && r_reg.op == FPG_OP_PROGRAM);

endmodule // fpg_flash_guard

// file: hdl/fpg_pkg.sv
// Package of constants and types for the flash program and erase guard
package fpg_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] FPG_CTRL_ADDR      = 12'hff8;
   localparam logic [11:0] FPG_PAGE_ADDR      = 12'hff9;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  FPG_CMD_RESET      = 8'h00;
   localparam logic [7:0]  FPG_CMD_UNLOCK1    = 8'h73;
   localparam logic [7:0]  FPG_CMD_UNLOCK2    = 8'h8c;
   localparam logic [7:0]  FPG_CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0]  FPG_CMD_MASS_ERASE = 8'h63;
   localparam logic [7:0]  FPG_CMD_PROT_SEL   = 8'h5e;

   // ----------------------------------------------------------------
   // Reset values, field positions, status codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  FPG_PROT_RESET     = 8'h00;
   localparam logic [7:0]  FPG_PAGE_RESET     = 8'h00;
   localparam logic [7:0]  FPG_ERASED_BYTE    = 8'hff;
   localparam int          FPG_PAGE_LSB       = 9;
   localparam int          FPG_PAGE_BITS      = 7;
   localparam int          FPG_INFO_BIT       = 7;
   localparam logic [5:0]  FPG_ST_LOCKED      = 6'h00;
   localparam logic [5:0]  FPG_ST_UNLOCK1     = 6'h01;
   localparam logic [5:0]  FPG_ST_UNLOCK2     = 6'h02;
   localparam logic [5:0]  FPG_ST_UNLOCKED    = 6'h03;
   localparam logic [5:0]  FPG_ST_PROT        = 6'h04;
   localparam logic [5:0]  FPG_ST_PROGRAM     = 6'h08;
   localparam logic [5:0]  FPG_ST_PAGE_ERASE  = 6'h10;
   localparam logic [5:0]  FPG_ST_MASS_ERASE  = 6'h20;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          FPG_CLK_MHZ        = 100;
   localparam int          FPG_PROG_TIME_NS   = 40;
   localparam int          FPG_PROG_CYCLES    = (FPG_PROG_TIME_NS * FPG_CLK_MHZ + 999) / 1000;
   localparam int          FPG_ERASE_CYCLES   = 16;

   typedef enum logic [2:0] {
      FPG_LOCKED,
      FPG_GOT_FIRST,
      FPG_GOT_SECOND,
      FPG_UNLOCKED,
      FPG_PROT_SEL,
      FPG_BUSY
   } fpg_state_type;

   typedef enum logic [1:0] {
      FPG_OP_PROGRAM,
      FPG_OP_PAGE_ERASE,
      FPG_OP_MASS_ERASE
   } fpg_op_type;

endpackage

// file: hdl/fpg_sector_map.sv
// Sector index and protection lookup for a flash address
`timescale 1ns/10ps
module fpg_sector_map
   import fpg_pkg::*;
#(
   parameter int ADDR_W     = 16,
   parameter int FLASH_SIZE = 24576,
   parameter int PAGE_SIZE  = 512
)(
   input  wire logic [ADDR_W-1:0] addr_i,       // Flash byte address
   input  wire logic [7:0]        prot_i,       // Sector protect bits
   output logic [2:0]             sector_o,     // Sector index
   output logic                   protected_o   // Sector is protected
);
   // Eighth of memory, but never below one page
   localparam int SECTOR_SIZE = (FLASH_SIZE / 8 < PAGE_SIZE) ? PAGE_SIZE : FLASH_SIZE / 8; // R8

   logic [ADDR_W-1:0] idx;

   always_comb
   begin
      idx         = addr_i / ADDR_W'(SECTOR_SIZE); // R8
      sector_o    = (idx > ADDR_W'(7)) ? 3'd7 : idx[2:0];
      protected_o = prot_i[sector_o];
   end

endmodule // fpg_sector_map

// file: test/fpg_flash_model.sv
// Behavioural flash array that answers the guard's byte port
`timescale 1ns/10ps
module fpg_flash_model
#(
   parameter int ADDR_W     = 16,
   parameter int FLASH_SIZE = 2048
)(
   input  wire logic              ref_clk_i, // System clock
   input  wire logic              we_i,      // Byte write strobe
   input  wire logic [ADDR_W-1:0] addr_i,    // Byte address
   input  wire logic [7:0]        wdata_i,   // Byte data
   output logic [7:0]             rdata_o    // Byte at addr_i
);
   // ----------------------------------------------------------------
   // Array
   // ----------------------------------------------------------------
   logic [7:0] mem [FLASH_SIZE];

   // Stores what it is sent, so clearing bits only is left to the guard
   initial foreach (mem[i]) mem[i] = 8'hff;
   assign rdata_o = mem[addr_i % FLASH_SIZE];
   always @(posedge ref_clk_i)
   begin
      if (we_i) mem[addr_i % FLASH_SIZE] <= wdata_i;
   end
endmodule // fpg_flash_model

// file: test/tb_flash_program_erase_guard.sv
// Self-checking bench for the flash program and erase guard
`timescale 1ns/10ps
module tb_flash_program_erase_guard;
   import fpg_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   // Small array: four 512-byte sectors, keeps mass erase short
   localparam int FSIZE = 2048;
   logic        ref_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        wp_option_i = 1'b1;
   logic        debugger_port_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [11:0] reg_addr_i = 12'h000;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        prog_req_i = 1'b0;
   logic [15:0] prog_addr_i = 16'h0000;
   logic [7:0]  prog_data_i = 8'h00;
   logic [7:0]  mem_rdata_i, reg_rdata_o, mem_wdata_o, sector_prot_o, v;
   logic        cpu_stall_o, mem_we_o;
   logic [15:0] mem_addr_o;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;

   fpg_flash_guard #(.ADDR_W(16), .FLASH_SIZE(FSIZE), .PAGE_SIZE(512)) dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .wp_option_i(wp_option_i),
      .debugger_port_i(debugger_port_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .prog_req_i(prog_req_i),
      .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i), .mem_rdata_i(mem_rdata_i),
      .reg_rdata_o(reg_rdata_o), .cpu_stall_o(cpu_stall_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .sector_prot_o(sector_prot_o));

   fpg_flash_model #(.ADDR_W(16), .FLASH_SIZE(FSIZE)) flash (
      .ref_clk_i(ref_clk_i), .we_i(mem_we_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

   // Runs at FPG_CLK_MHZ, the rate the guard times its operations with
   initial forever #5 ref_clk_i = ~ref_clk_i;

   // Mass erase of the small array is the longest step, about 35k cycles
   always @(posedge ref_clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 80000)
      begin
         failures++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("failures=%0d checks_done=%0d", failures, checks_done);
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         failures++;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_i = 1'b0;
      d = reg_rdata_o;
   endtask

   task automatic chk_st(input logic [5:0] exp);
      logic [7:0] s;
      rd(FPG_CTRL_ADDR, s);
      chk(s, {2'b00, exp});
   endtask

   task automatic unlock(input logic [7:0] page, input logic dbg);
      wr(FPG_PAGE_ADDR, page);
      wr(FPG_CTRL_ADDR, FPG_CMD_UNLOCK1);
      wr(FPG_CTRL_ADDR, FPG_CMD_UNLOCK2);
      if (!dbg) wr(FPG_PAGE_ADDR, page);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (cpu_stall_o !== 1'b0 && n < 40000)
      begin
         @(negedge ref_clk_i);
         n++;
      end
      // The last byte strobe lands one edge after stall falls
      @(negedge ref_clk_i);
      if (n >= 40000) chk(8'h01, 8'h00);
   endtask

   task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic busy);
      @(negedge ref_clk_i);
      prog_addr_i = a;
      prog_data_i = d;
      prog_req_i = 1'b1;
      @(negedge ref_clk_i);
      prog_req_i = 1'b0;
      @(negedge ref_clk_i);
      chk({7'h00, cpu_stall_o}, {7'h00, busy});
      wait_idle();
   endtask

   task automatic do_reset();
      reset_i = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      reset_i = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      do_reset();
      chk_st(FPG_ST_LOCKED);
      chk(sector_prot_o, FPG_PROT_RESET);
      chk({7'h00, cpu_stall_o}, 8'h00);
      wr(FPG_PAGE_ADDR, 8'h01);
      wr(FPG_CTRL_ADDR, FPG_CMD_UNLOCK1);
      chk_st(FPG_ST_UNLOCK1);
      wr(FPG_CTRL_ADDR, FPG_CMD_UNLOCK2);
      chk_st(FPG_ST_UNLOCK2);
      wr(FPG_PAGE_ADDR, 8'h01);
      chk_st(FPG_ST_UNLOCKED);
      rd(FPG_PAGE_ADDR, v);
      chk(v, 8'h01);
      prog(16'h0210, 8'ha5, 1'b1);
      chk(flash.mem[16'h0210], 8'ha5);
      chk_st(FPG_ST_UNLOCKED);
      prog(16'h0210, 8'h5a, 1'b1);
      chk(flash.mem[16'h0210], 8'h00);
      prog(16'h0410, 8'h00, 1'b0);
      chk(flash.mem[16'h0410], 8'hff);
      wr(FPG_CTRL_ADDR, 8'h11);
      chk_st(FPG_ST_LOCKED);
      unlock(8'h01, 1'b0);
      wr(FPG_PAGE_ADDR, 8'h02);
      wr(FPG_CTRL_ADDR, FPG_CMD_UNLOCK1);
      wr(FPG_CTRL_ADDR, FPG_CMD_UNLOCK2);
      wr(FPG_PAGE_ADDR, 8'h03);
      chk_st(FPG_ST_LOCKED);
      wr(FPG_PAGE_ADDR, 8'h01);
      wr(FPG_CTRL_ADDR, FPG_CMD_UNLOCK2);
      chk_st(FPG_ST_LOCKED);
      // Page erase must cover the whole page and leave the byte below it alone
      flash.mem[16'h01ff] = 8'h12;
      flash.mem[16'h03ff] = 8'h34;
      flash.mem[16'h0200] = 8'h56;
      unlock(8'h01, 1'b0);
      wr(FPG_CTRL_ADDR, FPG_CMD_PAGE_ERASE);
      @(negedge ref_clk_i);
      chk({7'h00, cpu_stall_o}, 8'h01);
      wait_idle();
      chk(flash.mem[16'h0210], FPG_ERASED_BYTE);
      chk(flash.mem[16'h03ff], FPG_ERASED_BYTE);
      chk(flash.mem[16'h01ff], 8'h12);
      chk(flash.mem[16'h0200], FPG_ERASED_BYTE);
      chk_st(FPG_ST_LOCKED);
      wp_option_i = 1'b0;
      unlock(8'h01, 1'b0);
      prog(16'h0220, 8'h00, 1'b1);
      chk(flash.mem[16'h0220], 8'hff);
      chk_st(FPG_ST_LOCKED);
      wp_option_i = 1'b1;
      unlock(8'h00, 1'b0);
      wr(FPG_CTRL_ADDR, FPG_CMD_MASS_ERASE);
      chk({7'h00, cpu_stall_o}, 8'h00);
      chk_st(FPG_ST_LOCKED);
      wr(FPG_CTRL_ADDR, FPG_CMD_RESET);
      wr(FPG_CTRL_ADDR, FPG_CMD_PROT_SEL);
      chk_st(FPG_ST_PROT);
      wr(FPG_PAGE_ADDR, 8'h02);
      wr(FPG_PAGE_ADDR, 8'h00);
      chk(sector_prot_o, 8'h02);
      rd(FPG_PAGE_ADDR, v);
      chk(v, 8'h02);
      wr(FPG_CTRL_ADDR, FPG_CMD_RESET);
      chk_st(FPG_ST_LOCKED);
      unlock(8'h01, 1'b0);
      chk_st(FPG_ST_UNLOCKED);
      prog(16'h0220, 8'h00, 1'b1);
      chk(flash.mem[16'h0220], 8'hff);
      chk_st(FPG_ST_LOCKED);
      unlock(8'h00, 1'b0);
      prog(16'h01fe, 8'h0f, 1'b1);
      chk(flash.mem[16'h01fe], 8'h0f);
      // Debugger mass erase with option cleared and a sector protected
      wr(FPG_CTRL_ADDR, FPG_CMD_RESET);
      chk_st(FPG_ST_LOCKED);
      flash.mem[16'h07ff] = 8'h00;
      flash.mem[16'h0000] = 8'h00;
      wp_option_i = 1'b0;
      debugger_port_i = 1'b1;
      unlock(8'h00, 1'b1);
      chk_st(FPG_ST_UNLOCKED);
      wr(FPG_CTRL_ADDR, FPG_CMD_MASS_ERASE);
      @(negedge ref_clk_i);
      chk({7'h00, cpu_stall_o}, 8'h01);
      wait_idle();
      chk(flash.mem[16'h07ff], FPG_ERASED_BYTE);
      chk(flash.mem[16'h0000], FPG_ERASED_BYTE);
      chk(flash.mem[16'h01fe], FPG_ERASED_BYTE);
      chk(flash.mem[16'h0210], FPG_ERASED_BYTE);
      chk_st(FPG_ST_LOCKED);
      do_reset();
      chk(sector_prot_o, FPG_PROT_RESET);
      chk_st(FPG_ST_LOCKED);
      debugger_port_i = 1'b0;
      wr(FPG_CTRL_ADDR, FPG_CMD_PROT_SEL);
      wr(FPG_PAGE_ADDR, 8'h80);
      debugger_port_i = 1'b1;
      wr(FPG_PAGE_ADDR, 8'h00);
      chk(sector_prot_o, 8'h00);
      close_out();
   end
endmodule // tb_flash_program_erase_guard
